// ===== rtl/lane_delay_ram.v
// Small per-lane delay memory with registered read data.
`timescale 1ns/1ps
module lane_delay_ram #(
  parameter WIDTH = 9,
  parameter AW = 3
) (
  input wire clk,
  input wire en,
  input wire [AW-1:0] wrAddr,
  input wire [WIDTH-1:0] wrData,
  input wire [AW-1:0] rdAddr,
  output reg [WIDTH-1:0] rdData
);
  reg [WIDTH-1:0] mem [0:(1<<AW)-1];

  always @(posedge clk) begin
    if (en) begin
      mem[wrAddr] <= wrData;
      rdData <= mem[rdAddr];
    end
  end
endmodule

// ===== rtl/lane_train_map.vh
// Symbol codes, field values, state codes and counts for lane training.
`ifndef LANE_TRAIN_MAP_VH
`define LANE_TRAIN_MAP_VH
`define SYM_COM 8'hbc
`define SYM_FTS 8'h3c
`define SYM_SKP 8'h1c
`define SYM_TS1_ID 8'h4a
`define SYM_TS1_INV 8'hb5
`define SYM_TS2_ID 8'h45
`define SYM_TS2_INV 8'hba
`define TS_ID_FIRST 4'h6
`define TS_ID_LAST 4'hf
`define RATE_ID_GEN1 8'h02
`define TS_CTRL_IDLE 8'h00
`define FTS_MAX_REQ 8'hff
`define FTS_LONG_COUNT 4096
`define FTS_SET_LEN 4
`define SKP_SET_LEN 11'h004
`define LT_DETECT 3'h0
`define LT_POLLING 3'h1
`define LT_CONFIG 3'h2
`define LT_RECOVERY 3'h3
`define LT_L0 3'h4
`define LT_L0S 3'h5
`define LT_OTHER 3'h6
`endif

// ===== rtl/serial_lane_training.v
// Lane polarity, fast training, error reaction, width and de-skew logic.
//
// Behaviour
// R1 - Symbols 6-15 reading D21.5 in TS1 or D26.5 in TS2 flag swapped polarity.
// R2 - A flagged lane inverts all its received data, each lane on its own.
// R3 - Transmit data is never inverted.
// R4 - A fast training set is one K28.5 then three K28.1.
// R5 - Requested fast training count is at most 255; that many sent on L0s exit.
// R6 - Long-lock request makes the transmitter send 4096 fast training sets.
// R7 - No SKP during the first requested sets; scheduled SKP allowed afterwards.
// R8 - Exactly one SKP follows the last set; a scheduled one may follow.
// R9 - Lock window expiring before lock and de-skew on all lanes forces Recovery.
// R10 - Every decode error raises the receive-error report. Here errors on lanes outside the link width are masked.
// R11 - In L0 link errors may move the state machine to Recovery.
// R12 - Outside L0 link errors never start a state transition.
// R13 - After a set number of decode errors a lane re-checks symbol lock.
// R14 - Release of fundamental reset returns the state machine to its start.
// R15 - Training starts at first-generation rate, advertising supported rates.
// R16 - Link widths are 1, 2, 4, 8, 12, 16 or 32 lanes at one frequency.
// R17 - A port of width N forms width-N or single-lane links.
// R18 - Lane reversal applies to transmitter and receiver alike.
// R19 - Each linked lane gets link and lane numbers; others stay idle. Here every lane gets a lane number and none a link number.
// R20 - Receiver removes inter-lane skew before passing data upward.
// R21 - De-skew runs in Configuration, Recovery and L0s.
// R22 - Training set symbols 3, 4 and 5 match on all lanes.
// R23 - Rate identifier has bit 1 set and all other bits zero.
// R24 - Symbol 3 carries the receiver's own fast training count.
// R25 - Lock window counted in symbols from four times count plus SKP.
`timescale 1ns/1ps
`include "lane_train_map.vh"
module serial_lane_training #(
  parameter LANES = 4,
  parameter OWN_NFTS = 8'h80,
  parameter LONG_FTS = `FTS_LONG_COUNT,
  parameter ERR_LIMIT = 4'h8,
  parameter RECOVER_ON_ERR = 1'b1,
  parameter DAW = 3,
  parameter MAX_SKEW = 5
) (
  input wire sys_clk,
  input wire sys_rst,
  input wire clkEn,
  input wire fundRst,
  input wire [2:0] ltssmState,
  input wire [LANES*10-1:0] rxRawCode,
  input wire [LANES*8-1:0] rxSym,
  input wire [LANES-1:0] rxIsK,
  input wire [LANES-1:0] rxDecodeErr,
  input wire [LANES-1:0] rxBitLock,
  input wire [LANES-1:0] rxSymLock,
  input wire l0sExitSeen,
  input wire ftsStart,
  input wire [7:0] partnerNfts,
  input wire longLock,
  input wire skpDue,
  input wire [5:0] partnerWidth,
  input wire laneReverse,
  input wire configDone,
  output reg [LANES*10-1:0] rxCodeFixed,
  output reg [LANES-1:0] polarityFlip,
  output reg [LANES*9-1:0] rxAligned,
  output reg deskewOk,
  output reg [7:0] txSym,
  output reg txIsK,
  output reg txActive,
  output reg [7:0] tsNfts,
  output reg [7:0] tsRateId,
  output reg [7:0] tsCtrl,
  output reg [LANES*5-1:0] txLaneNum,
  output reg [LANES-1:0] laneIdle,
  output reg [5:0] linkWidth,
  output reg linkUp,
  output reg laneReversed,
  output reg rxErrReport,
  output reg goRecovery,
  output reg [LANES-1:0] symLockCheck,
  output reg ltssmInit
);
  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  function isCom;
    input [7:0] sym;
    input k;
    begin
      isCom = k && (sym == `SYM_COM);
    end
  endfunction

  // A port of width N forms width N, or falls back to a single lane.
  function [5:0] fitWidth;
    input [5:0] offered;
    begin
      if (offered >= LANES[5:0])
        fitWidth = LANES[5:0];
      else
        fitWidth = 6'h01;
    end
  endfunction

  localparam [10:0] LOCK_LOAD = 11'h004 * {3'h0, OWN_NFTS[7:0]} +
                                `SKP_SET_LEN;

  wire deskewEn = (ltssmState == `LT_CONFIG) ||
                  (ltssmState == `LT_RECOVERY) ||
                  (ltssmState == `LT_L0S);
  wire inDetect = (ltssmState == `LT_DETECT);
  reg [LANES-1:0] laneMask;
  integer m;
  always @* begin
    for (m = 0; m < LANES; m = m + 1)
      laneMask[m] = linkUp ? (m < linkWidth) : 1'b1;
  end

  // ----------------------------------------------------------------
  // Per-lane polarity, error counting and delay memory
  // ----------------------------------------------------------------
  reg [DAW-1:0] wrPtr;
  reg [DAW-1:0] laneDelay [0:LANES-1];
  wire [LANES*9-1:0] ramOut;
  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1) begin : lane
      wire [7:0] sym = rxSym[g*8 +: 8];
      wire isK = rxIsK[g];
      reg [3:0] tsIdx;
      reg inSet;
      reg [3:0] errCnt;
      always @(posedge sys_clk) begin
        if (sys_rst) begin
          tsIdx <= 4'h0;
          inSet <= 1'b0;
          polarityFlip[g] <= 1'b0;
          rxCodeFixed[g*10 +: 10] <= 10'h000;
          errCnt <= 4'h0;
          symLockCheck[g] <= 1'b0;
        end else if (clkEn) begin
          // R2 invert flagged lane
          rxCodeFixed[g*10 +: 10] <= polarityFlip[g] ?
            ~rxRawCode[g*10 +: 10] : rxRawCode[g*10 +: 10];
          if (isCom(sym, isK)) begin
            tsIdx <= 4'h1;
            inSet <= 1'b1;
          end else if (inSet) begin
            tsIdx <= tsIdx + 4'h1;
            if (tsIdx == `TS_ID_LAST)
              inSet <= 1'b0;
          end
          if (inDetect) begin
            polarityFlip[g] <= 1'b0;
          // R1 inverted identifier check
          end else if (inSet && !isK && tsIdx >= `TS_ID_FIRST &&
                       (sym == `SYM_TS1_INV || sym == `SYM_TS2_INV)) begin
            polarityFlip[g] <= 1'b1;
          end
          // R13 lock re-check trigger
          symLockCheck[g] <= 1'b0;
          if (rxDecodeErr[g]) begin
            if (errCnt == ERR_LIMIT - 4'h1) begin
              errCnt <= 4'h0;
              symLockCheck[g] <= 1'b1;
            end else begin
              errCnt <= errCnt + 4'h1;
            end
          end
        end
      end
      lane_delay_ram #(
        .WIDTH(9),
        .AW(DAW)
      ) ram (
        .clk(sys_clk),
        .en(clkEn),
        .wrAddr(wrPtr),
        .wrData({isK, sym}),
        .rdAddr(wrPtr - laneDelay[g] - {{(DAW-1){1'b0}}, 1'b1}),
        .rdData(ramOut[g*9 +: 9])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Inter-lane de-skew on comma arrival times
  // ----------------------------------------------------------------
  reg [4:0] stampCnt;
  reg [4:0] arrival [0:LANES-1];
  reg [LANES-1:0] gotCom;
  reg deskewEnD;
  reg [4:0] latest;
  reg allGot;
  reg skewBad;
  integer d;
  always @* begin
    latest = 5'h00;
    allGot = 1'b1;
    skewBad = 1'b0;
    for (d = 0; d < LANES; d = d + 1) begin
      if (laneMask[d] && !gotCom[d])
        allGot = 1'b0;
      if (laneMask[d] && arrival[d] > latest)
        latest = arrival[d];
    end
    for (d = 0; d < LANES; d = d + 1) begin
      if (laneMask[d] && (latest - arrival[d]) > MAX_SKEW)
        skewBad = 1'b1;
    end
  end

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      wrPtr <= {DAW{1'b0}};
      stampCnt <= 5'h00;
      gotCom <= {LANES{1'b0}};
      deskewEnD <= 1'b0;
      deskewOk <= 1'b0;
      for (d = 0; d < LANES; d = d + 1) begin
        arrival[d] <= 5'h00;
        laneDelay[d] <= {DAW{1'b0}};
      end
    end else if (clkEn) begin
      wrPtr <= wrPtr + {{(DAW-1){1'b0}}, 1'b1};
      deskewEnD <= deskewEn;
      // R21 de-skew in training states
      if (deskewEn && (!deskewEnD || stampCnt == 5'h1f ||
                       (allGot && skewBad))) begin
        stampCnt <= 5'h00;
        gotCom <= {LANES{1'b0}};
        deskewOk <= 1'b0;
      end else if (deskewEn && allGot) begin
        // R20 align lanes on commas
        deskewOk <= 1'b1;
        for (d = 0; d < LANES; d = d + 1)
          laneDelay[d] <= laneMask[d] ?
            latest[DAW-1:0] - arrival[d][DAW-1:0] : {DAW{1'b0}};
      end else if (deskewEn) begin
        stampCnt <= stampCnt + 5'h01;
        for (d = 0; d < LANES; d = d + 1) begin
          if (!gotCom[d] && isCom(rxSym[d*8 +: 8], rxIsK[d])) begin
            gotCom[d] <= 1'b1;
            arrival[d] <= stampCnt;
          end
        end
      end
      if (inDetect)
        deskewOk <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Fast training transmitter
  // ----------------------------------------------------------------
  localparam [2:0] TX_IDLE = 3'h0;
  localparam [2:0] TX_FTS = 3'h1;
  localparam [2:0] TX_SKPS = 3'h2;
  localparam [2:0] TX_SKPL = 3'h3;
  localparam [2:0] TX_SKPX = 3'h4;
  reg [2:0] txState;
  reg [2:0] next_txState;
  reg [1:0] symIdx;
  reg [12:0] setCnt;
  reg [12:0] setTarget;
  reg [12:0] reqSets;
  reg [12:0] next_setCnt;
  reg [7:0] next_txSym;
  reg next_txIsK;
  wire setEnd = (symIdx == 2'h3);
  // R5 requested count clipped to the maximum
  wire [7:0] nftsReq = (partnerNfts > `FTS_MAX_REQ) ?
                       `FTS_MAX_REQ : partnerNfts;

  always @* begin
    next_txState = txState;
    next_setCnt = setCnt;
    next_txSym = 8'h00;
    next_txIsK = 1'b0;
    case (txState)
      TX_IDLE: begin
      end
      TX_FTS: begin
        // R4 comma then three fast training symbols
        next_txIsK = 1'b1;
        next_txSym = (symIdx == 2'h0) ? `SYM_COM : `SYM_FTS;
        if (setEnd) begin
          next_setCnt = setCnt + 13'h0001;
          if (next_setCnt == setTarget)
            next_txState = TX_SKPL;
          // R7 no SKP inside the first requested sets
          else if (skpDue && next_setCnt >= reqSets)
            next_txState = TX_SKPS;
        end
      end
      TX_SKPS, TX_SKPL, TX_SKPX: begin
        next_txIsK = 1'b1;
        next_txSym = (symIdx == 2'h0) ? `SYM_COM : `SYM_SKP;
        if (setEnd) begin
          case (txState)
            TX_SKPS: next_txState = TX_FTS;
            // R8 one SKP after the last set, maybe one more
            TX_SKPL: next_txState = skpDue ? TX_SKPX : TX_IDLE;
            default: next_txState = TX_IDLE;
          endcase
        end
      end
      default: next_txState = TX_IDLE;
    endcase
  end

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      txState <= TX_IDLE;
      symIdx <= 2'h0;
      setCnt <= 13'h0000;
      setTarget <= 13'h0000;
      reqSets <= 13'h0000;
      txSym <= 8'h00;
      txIsK <= 1'b0;
      txActive <= 1'b0;
    end else if (clkEn) begin
      // R3 transmit path has no inversion
      txSym <= next_txSym;
      txIsK <= next_txIsK;
      txActive <= (txState != TX_IDLE);
      if (txState == TX_IDLE) begin
        symIdx <= 2'h0;
        setCnt <= 13'h0000;
        if (ftsStart) begin
          reqSets <= {5'h00, nftsReq};
          // R6 long-lock count overrides the request
          setTarget <= longLock ? LONG_FTS[12:0] : {5'h00, nftsReq};
          if (!longLock && nftsReq == 8'h00)
            txState <= TX_SKPL;
          else
            txState <= TX_FTS;
        end
      end else begin
        symIdx <= symIdx + 2'h1;
        setCnt <= next_setCnt;
        txState <= next_txState;
      end
    end
  end

  // ----------------------------------------------------------------
  // Lock window, error report and Recovery request
  // ----------------------------------------------------------------
  reg [10:0] lockTimer;
  reg lockRun;
  wire allLocked = (&((rxBitLock & rxSymLock) | ~laneMask)) && deskewOk;
  wire anyErr = |(rxDecodeErr & laneMask);

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      lockTimer <= 11'h000;
      lockRun <= 1'b0;
      goRecovery <= 1'b0;
      rxErrReport <= 1'b0;
    end else if (clkEn) begin
      // R10 decode errors reported
      rxErrReport <= anyErr;
      goRecovery <= 1'b0;
      // R25 symbol-time lock window
      if (l0sExitSeen) begin
        lockTimer <= LOCK_LOAD;
        lockRun <= 1'b1;
      end else if (lockRun) begin
        if (allLocked) begin
          lockRun <= 1'b0;
        end else if (lockTimer == 11'h000) begin
          // R9 timeout forces Recovery
          lockRun <= 1'b0;
          goRecovery <= 1'b1;
        end else begin
          lockTimer <= lockTimer - 11'h001;
        end
      end
      // R11 errors in L0 request Recovery
      // R12 other states ignore errors
      if (RECOVER_ON_ERR && anyErr && ltssmState == `LT_L0)
        goRecovery <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Reset release, width, lane numbering and training fields
  // ----------------------------------------------------------------
  reg fundRstD;
  integer n;
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      fundRstD <= 1'b0;
      ltssmInit <= 1'b0;
      linkWidth <= 6'h00;
      linkUp <= 1'b0;
      laneReversed <= 1'b0;
      laneIdle <= {LANES{1'b1}};
      txLaneNum <= {LANES*5{1'b0}};
      rxAligned <= {LANES*9{1'b0}};
      tsNfts <= 8'h00;
      tsRateId <= 8'h00;
      tsCtrl <= 8'h00;
    end else if (clkEn) begin
      fundRstD <= fundRst;
      // R14 initialise on reset release
      ltssmInit <= fundRstD && !fundRst;
      // R22 common training fields on every lane
      // R24 own fast training count advertised
      tsNfts <= OWN_NFTS[7:0];
      // R15 first-generation rate advertised
      // R23 only the first-generation rate bit
      tsRateId <= `RATE_ID_GEN1;
      tsCtrl <= `TS_CTRL_IDLE;
      if (inDetect || fundRst) begin
        linkUp <= 1'b0;
        linkWidth <= 6'h00;
        laneReversed <= 1'b0;
      end else if (configDone) begin
        // R16 legal width only
        // R17 full width or single lane
        linkWidth <= fitWidth(partnerWidth);
        linkUp <= 1'b1;
        laneReversed <= laneReverse && (fitWidth(partnerWidth) > 6'h01);
      end
      for (n = 0; n < LANES; n = n + 1) begin
        // R19 unlinked lanes held idle
        laneIdle[n] <= linkUp && !(n < linkWidth);
        // R18 reversal on both directions
        txLaneNum[n*5 +: 5] <= laneReversed ?
          LANES[4:0] - 5'h01 - n[4:0] : n[4:0];
        rxAligned[n*9 +: 9] <= laneReversed ?
          ramOut[(LANES-1-n)*9 +: 9] : ramOut[n*9 +: 9];
      end
    end
  end
endmodule

// ===== sim/lane_partner.sv
// Behavioural link partner sending training sets with per-lane skew.
`timescale 1ns/1ps
`include "lane_train_map.vh"
module lane_partner #(
  parameter LANES = 4,
  parameter NFTS = 8'h10
) (
  input wire sys_clk,
  input wire active,
  input wire ts2,
  input wire [LANES-1:0] invMask,
  output logic [LANES*10-1:0] rxRawCode = '0,
  output logic [LANES*8-1:0] rxSym = '0,
  output logic [LANES-1:0] rxIsK = '0
);
  logic [3:0] idx = 4'h0;
  logic [3:0] p;
  logic [7:0] s;
  int n;
  // --------------------------------------------------------------
  // Training stream, lane n running n symbols late
  // --------------------------------------------------------------
  always @(posedge sys_clk) begin
    idx <= idx + 4'h1;
    for (n = 0; n < LANES; n++) begin
      p = idx - 4'(n);
      case (p)
        4'h0: s = `SYM_COM;
        4'h1: s = 8'h00;
        4'h2: s = 8'(n);
        4'h3: s = NFTS;
        4'h4: s = `RATE_ID_GEN1;
        4'h5: s = `TS_CTRL_IDLE;
        // identifier as seen through a swapped pair
        default: s = ts2 ? (invMask[n] ? `SYM_TS2_INV : `SYM_TS2_ID) :
          (invMask[n] ? `SYM_TS1_INV : `SYM_TS1_ID);
      endcase
      // A released lane shows the inverse of its last symbol.
      if (!active) s = ~rxSym[n*8 +: 8];
      rxSym[n*8 +: 8] <= s;
      rxIsK[n] <= active && p == 4'h0;
      rxRawCode[n*10 +: 10] <= {p == 4'h0, s, 1'b0} ^ {10{invMask[n]}};
    end
  end
endmodule

// ===== sim/serial_lane_training_asserts.sv
// Port checker for the lane training block.
`timescale 1ns/1ps
`include "lane_train_map.vh"
module serial_lane_training_asserts #(
  parameter LANES = 4,
  parameter OWN_NFTS = 8'h80,
  parameter ERR_LIMIT = 4'h8
) (
  input wire sys_clk,
  input wire sys_rst,
  input wire clkEn,
  input wire fundRst,
  input wire ftsStart,
  input wire configDone,
  input wire [2:0] ltssmState,
  input wire [5:0] partnerWidth,
  input wire [LANES-1:0] rxDecodeErr,
  input wire [LANES*10-1:0] rxRawCode,
  input wire [LANES*10-1:0] rxCodeFixed,
  input wire [LANES-1:0] polarityFlip,
  input wire [7:0] txSym,
  input wire txIsK,
  input wire txActive,
  input wire [7:0] tsNfts,
  input wire [7:0] tsRateId,
  input wire [7:0] tsCtrl,
  input wire [LANES-1:0] laneIdle,
  input wire [5:0] linkWidth,
  input wire linkUp,
  input wire rxErrReport,
  input wire goRecovery,
  input wire [LANES-1:0] symLockCheck,
  input wire ltssmInit
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // Decode errors seen on lane 0 since the last lock check.
  reg [3:0] errCnt;
  wire err0 = rxDecodeErr[0] && !laneIdle[0];
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      errCnt <= 4'h0;
    end else if (err0) begin
      errCnt <= (errCnt == ERR_LIMIT - 1) ? 4'h0 : errCnt + 4'h1;
    end
  end
  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  a_burst_head: assert property (ftsStart && !txActive
    |-> ##2 txActive && txIsK && txSym == `SYM_COM) else $error("bad head");
  a_set_body: assert property (txActive && txIsK && txSym == `SYM_COM
    |=> txIsK && (txSym == `SYM_FTS || txSym == `SYM_SKP)
    ##1 $stable(txSym) [*2]) else $error("bad set body");
  a_tx_plain: assert property (txActive |-> txIsK &&
    (txSym == `SYM_COM || txSym == `SYM_FTS || txSym == `SYM_SKP))
    else $error("odd transmit symbol");
  a_err_report: assert property ((rxDecodeErr & ~laneIdle) != 0
    |=> rxErrReport) else $error("error not reported");
  a_err_recover: assert property (ltssmState == `LT_L0 &&
    (rxDecodeErr & ~laneIdle) != 0 |=> goRecovery) else $error("no recovery");
  a_quiet_outside: assert property (ltssmState < `LT_L0 &&
    $past(ltssmState) < `LT_L0 |=> !goRecovery) else $error("recovery kick");
  a_lock_check: assert property (err0 && errCnt == ERR_LIMIT - 1
    |=> symLockCheck[0]) else $error("no lock check");
  a_fund_init: assert property ($fell(fundRst)
    |-> ##[0:2] ltssmInit) else $error("no init pulse");
  a_ts_fields: assert property (!$past(sys_rst) |->
    tsRateId == `RATE_ID_GEN1 && tsNfts == OWN_NFTS &&
    tsCtrl == `TS_CTRL_IDLE) else $error("bad set fields");
  a_width_take: assert property (configDone |=> linkUp &&
    linkWidth == ($past(partnerWidth) >= LANES ? LANES : 1))
    else $error("bad width");
  a_flip_path: assert property (!$past(sys_rst) && $past(clkEn) &&
    polarityFlip[1:0] == $past(polarityFlip[1:0]) |-> rxCodeFixed[19:0] ==
    ($past(rxRawCode[19:0]) ^ {{10{polarityFlip[1]}}, {10{polarityFlip[0]}}}))
    else $error("bad code path");
  a_flip_sticky: assert property ($fell(polarityFlip[0])
    |-> $past(ltssmState) == `LT_DETECT) else $error("flag dropped");
endmodule
bind serial_lane_training serial_lane_training_asserts #(
  .LANES(LANES), .OWN_NFTS(OWN_NFTS), .ERR_LIMIT(ERR_LIMIT)
) chk (.sys_clk, .sys_rst, .clkEn, .fundRst, .ftsStart, .configDone,
  .ltssmState, .partnerWidth, .rxDecodeErr, .rxRawCode, .rxCodeFixed,
  .polarityFlip, .txSym, .txIsK, .txActive, .tsNfts, .tsRateId, .tsCtrl,
  .laneIdle, .linkWidth, .linkUp, .rxErrReport, .goRecovery, .symLockCheck,
  .ltssmInit);

// ===== sim/serial_lane_training_bench.sv
// Self-checking bench for the lane training block.
`timescale 1ns/1ps
`include "lane_train_map.vh"
module serial_lane_training_bench;
  typedef struct {
    logic [7:0] rq;
    logic ll;
    logic sd;
    int nf;
    int ns;
  } row_t;
  row_t rows [5] = '{'{8'h01, 1'b0, 1'b0, 1, 1}, '{8'h00, 1'b0, 1'b0, 0, 1},
    '{8'h03, 1'b0, 1'b1, 3, 2}, '{8'h02, 1'b1, 1'b0, 16, 1},
    '{8'hff, 1'b0, 1'b0, 255, 1}};
  logic sys_clk = 1'b0, sys_rst = 1'b1, clkEn = 1'b1, fundRst = 1'b0;
  logic ftsStart = 1'b0, longLock = 1'b0, skpDue = 1'b0, l0sExitSeen = 1'b0;
  logic laneReverse = 1'b0, configDone = 1'b0, active = 1'b1, ts2 = 1'b0;
  logic [2:0] ltssmState = `LT_POLLING;
  logic [3:0] rxDecodeErr = 4'h0, rxBitLock = 4'hf, rxSymLock = 4'hf;
  logic [3:0] invMask = 4'h0, rxIsK, polarityFlip, laneIdle, symLockCheck;
  logic [7:0] partnerNfts = 8'h00, txSym, tsNfts, tsRateId;
  logic [5:0] partnerWidth = 6'h04, linkWidth;
  logic [39:0] rxRawCode;
  logic [31:0] rxSym;
  logic [35:0] rxAligned;
  logic [19:0] txLaneNum;
  logic deskewOk, txIsK, txActive, linkUp, laneReversed, rxErrReport;
  logic goRecovery, ltssmInit;
  int badCount = 0, nChecks = 0, cycles = 0, i, a, b;
  serial_lane_training #(.LANES(4), .OWN_NFTS(8'h04), .LONG_FTS(16)) uut (
    .sys_clk, .sys_rst, .clkEn, .fundRst, .ltssmState, .rxRawCode, .rxSym,
    .rxIsK, .rxDecodeErr, .rxBitLock, .rxSymLock, .l0sExitSeen, .ftsStart,
    .partnerNfts, .longLock, .skpDue, .partnerWidth, .laneReverse,
    .configDone, .rxCodeFixed(), .polarityFlip, .rxAligned, .deskewOk,
    .txSym, .txIsK, .txActive, .tsNfts, .tsRateId, .tsCtrl(), .txLaneNum,
    .laneIdle, .linkWidth, .linkUp, .laneReversed, .rxErrReport,
    .goRecovery, .symLockCheck, .ltssmInit);
  lane_partner #(.LANES(4)) far (.sys_clk, .active, .ts2, .invMask,
    .rxRawCode, .rxSym, .rxIsK);
  always #5 sys_clk = ~sys_clk;
  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    nChecks++;
    if (seen !== exp) begin
      badCount++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", nChecks, badCount);
    if (badCount == 0 && nChecks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      badCount++;
      summarize();
    end
  end
  task automatic burst(input row_t r);
    int f, s, at, k;
    @(posedge sys_clk);
    partnerNfts <= r.rq;
    longLock <= r.ll;
    skpDue <= r.sd;
    ftsStart <= 1'b1;
    @(posedge sys_clk) ftsStart <= 1'b0;
    f = 0;
    s = 0;
    at = -1;
    for (k = 0; k < 2000 && (k < 2 || txActive); k++) begin
      @(posedge sys_clk);
      #1;
      if (txIsK && txSym == `SYM_FTS) f++;
      if (txIsK && txSym == `SYM_SKP) begin
        if (at < 0) at = f;
        s++;
      end
    end
    check(f, r.nf * 3);
    check(s, r.ns * 3);
    check(at, r.nf * 3);
  endtask
  task automatic cfg(input logic [5:0] w, input logic rev);
    @(posedge sys_clk);
    partnerWidth <= w;
    laneReverse <= rev;
    configDone <= 1'b1;
    @(posedge sys_clk) configDone <= 1'b0;
    @(posedge sys_clk);
    #1;
  endtask
  task automatic errRun(input logic [2:0] st, input int n);
    int e, r, l, k;
    e = 0;
    r = 0;
    l = 0;
    for (k = 0; k < 40; k++) begin
      @(posedge sys_clk);
      ltssmState <= st;
      rxDecodeErr <= {3'h0, k < 2 * n && k % 2 == 0};
      #1;
      e += rxErrReport;
      r += goRecovery;
      l += symLockCheck[0];
    end
    check(e, n);
    check(r, st == `LT_L0 ? n : 0);
    check(l, n / 8);
  endtask
  // --------------------------------------------------------------
  // Sequence
  // --------------------------------------------------------------
  initial begin
    repeat (16) @(posedge sys_clk);
    sys_rst <= 1'b0;
    #1 check(laneIdle, 4'hf);
    check({linkUp, txActive, polarityFlip}, 6'h00);
    @(posedge sys_clk) invMask <= 4'h1;
    repeat (40) @(posedge sys_clk);
    #1 check({tsRateId, tsNfts}, {`RATE_ID_GEN1, 8'h04});
    check(polarityFlip, 4'h1);
    @(posedge sys_clk);
    ts2 <= 1'b1;
    invMask <= 4'h4;
    repeat (40) @(posedge sys_clk);
    #1 check(polarityFlip, 4'h5);
    $display("test polarity finished");
    for (i = 0; i < 5; i++) burst(rows[i]);
    $display("test fast training finished");
    @(posedge sys_clk) ltssmState <= `LT_CONFIG;
    for (a = 0; a < 100 && deskewOk !== 1'b1; a++) begin
      @(posedge sys_clk);
      #1;
    end
    #1 check(deskewOk, 1'b1);
    for (a = 0; a < 40 && rxAligned[8:0] !== {1'b1, `SYM_COM}; a++) begin
      @(posedge sys_clk);
      #1;
    end
    check(rxAligned, {4{1'b1, `SYM_COM}});
    cfg(6'h04, 1'b0);
    check({linkUp, linkWidth, laneIdle}, {1'b1, 6'h04, 4'h0});
    cfg(6'h02, 1'b0);
    check(linkWidth, 6'h01);
    cfg(6'h04, 1'b1);
    check({laneReversed, txLaneNum[4:0]}, {1'b1, 5'h03});
    $display("test width finished");
    errRun(`LT_L0, 8);
    errRun(`LT_POLLING, 2);
    $display("test errors finished");
    @(posedge sys_clk);
    ltssmState <= `LT_L0S;
    rxSymLock <= 4'h7;
    l0sExitSeen <= 1'b1;
    @(posedge sys_clk) l0sExitSeen <= 1'b0;
    #1;
    // Ten frozen cycles inside the lock window delay the timeout by ten.
    for (a = 1; a < 50 && goRecovery !== 1'b1; a++) begin
      @(posedge sys_clk) clkEn <= (a < 2 || a > 11);
      #1;
    end
    check(a > 30 && a < 34, 1'b1);
    @(posedge sys_clk) fundRst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    fundRst <= 1'b0;
    rxSymLock <= 4'hf;
    b = 0;
    repeat (4) begin
      @(posedge sys_clk);
      #1 b += ltssmInit;
    end
    check({b[1:0], linkUp}, 3'h2);
    @(posedge sys_clk) ltssmState <= `LT_DETECT;
    repeat (3) @(posedge sys_clk);
    #1 check(polarityFlip, 4'h0);
    @(posedge sys_clk) sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    #1 check(laneIdle, 4'hf);
    $display("test recovery and reset finished");
    repeat (4) @(posedge sys_clk);
    summarize();
  end
endmodule
